/* rtl/brownout_filter.sv */
// Noise filter that trips only on a sustained dip below threshold.
`timescale 1ns/100ps
`default_nettype none
module brownout_filter (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  // Filter link
  brownout_filter_if.filter     filt
);
  localparam logic [reset_seq_pkg::FILTER_W-1:0] LIMIT =
    reset_seq_pkg::FILTER_W'(reset_seq_pkg::FILTER_CYCLES);

  logic [reset_seq_pkg::FILTER_W-1:0] cnt_ff;
  logic [reset_seq_pkg::FILTER_W-1:0] nxt_cnt;
  logic                               trip_ff;
  logic                               nxt_trip;

  always_comb begin
    nxt_cnt  = '0;
    nxt_trip = 1'h0;
    // A dip shorter than the filter time restarts the count.
    if (filt.enable && filt.below) begin
      nxt_trip = trip_ff || (cnt_ff == LIMIT);
      nxt_cnt  = (cnt_ff == LIMIT) ? cnt_ff
                                   : cnt_ff + 1'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      cnt_ff  <= '0;
      trip_ff <= 1'h0;
    end else begin
      cnt_ff  <= nxt_cnt;
      trip_ff <= nxt_trip;
    end
  end

  assign filt.tripped = trip_ff;
endmodule
`default_nettype wire

/* rtl/brownout_filter_if.sv */
// Interface between the sequencer and its brown-out noise filter.
`timescale 1ns/100ps
`default_nettype none
interface brownout_filter_if;
  logic below;
  logic enable;
  logic tripped;
  modport filter (input below, input enable, output tripped);
  modport user   (output below, output enable, input tripped);
endinterface
`default_nettype wire

/* rtl/brownout_powerup_reset.sv */
// Reset sequencer: power-on, brown-out and power-up timer for the core.
//
// Summary of operation
// - Hold core reset while supply below minimum.
// - Power-up timer gives nominal 64 ms delay.
// - Reset held until power-up timer expires.
// - Timer runs only when active-low enable cleared.
// - Timer starts after power-on and brown-out release.
// - Brown-out trips only after filtered sustained dip.
// - Two-bit field selects four brown-out modes.
// - Mode 11 always on; start waits ready.
// - Always-on protects in sleep, wake undelayed.
// - Mode 10 on awake, off asleep.
// - Mode 10 wake waits for ready.
// - Mode 01 soft bit enables; no start wait.
// - Soft mode protects once ready; ready readable.
// - Soft mode unaffected by sleep state.
// - Forced modes delay start until ready and supply above threshold.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module brownout_powerup_reset #(
  parameter int unsigned POWER_UP_CYCLES = reset_seq_pkg::POWER_UP_CYCLES
) (
  // Clock and reset
  input  wire logic                              ref_clk_in,
  input  wire logic                              nrst_in,
  // Supply detectors
  input  wire logic                              supply_low_in,
  input  wire logic                              below_threshold_in,
  input  wire logic                              brownout_ready_in,
  // Configuration bits
  input  wire logic [1:0]                        brownout_mode_select_in,
  input  wire logic                              power_up_timer_enable_n_in,
  // Core side
  input  wire logic                              sleep_in,
  output logic                                   core_reset_out,
  output logic                                   wake_hold_out,
  output logic                                   brownout_enable_out,
  output logic                                   brownout_reset_out,
  // Register port
  input  wire logic [reset_seq_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [reset_seq_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                              reg_write_in,
  input  wire logic                              reg_read_in,
  output logic      [reset_seq_pkg::DATA_W-1:0]  reg_rdata_out
);
  localparam logic [reset_seq_pkg::TIMER_W-1:0] TIMER_LAST =
    reset_seq_pkg::TIMER_W'(POWER_UP_CYCLES - 1);

  reset_seq_pkg::seq_state_type state_ff;
  reset_seq_pkg::seq_state_type nxt_state;
  logic [reset_seq_pkg::TIMER_W-1:0] timer_ff;
  logic [reset_seq_pkg::TIMER_W-1:0] nxt_timer;
  logic                              soft_en_ff;
  logic                              nxt_soft_en;
  logic                              core_reset_ff;
  logic                              nxt_core_reset;
  logic                              wake_hold_ff;
  logic                              nxt_wake_hold;
  logic                              bor_en_ff;
  logic                              nxt_bor_en;
  logic                              bor_rst_ff;
  logic                              nxt_bor_rst;
  logic [reset_seq_pkg::DATA_W-1:0]  rdata_ff;
  logic [reset_seq_pkg::DATA_W-1:0]  nxt_rdata;
  logic                              forced_mode;
  logic                              bor_active;
  logic                              start_ok;

  brownout_filter_if filt ();

  brownout_filter u_filter (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .filt       (filt.filter)
  );

  // Mode decode.
  always_comb begin
    forced_mode = 1'h0;
    bor_active  = 1'h0;
    case (brownout_mode_select_in)
      reset_seq_pkg::MODE_ALWAYS: begin
        forced_mode = 1'h1;
        bor_active  = 1'h1;
      end
      reset_seq_pkg::MODE_ON_AWAKE: begin
        forced_mode = 1'h1;
        bor_active  = !sleep_in;
      end
      reset_seq_pkg::MODE_SOFT: begin
        bor_active  = soft_en_ff;
      end
      default: begin
        bor_active  = 1'h0;
      end
    endcase
  end

  // Protection only bites once the detector is ready, which also covers
  // the soft mode where start-up never waits for it.
  assign filt.enable = bor_active && brownout_ready_in;
  assign filt.below  = below_threshold_in;

  // Forced modes wait for ready and good supply; the detector is already
  // forced on, but start-up stays in ST_READY_WAIT until it reports ready.
  assign start_ok = !forced_mode ||
                    (brownout_ready_in && !below_threshold_in);

  // Sequencer.
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    case (state_ff)
      reset_seq_pkg::ST_POWER_ON: begin
        if (start_ok) begin
          nxt_state = reset_seq_pkg::ST_TIMER;
        end else begin
          nxt_state = reset_seq_pkg::ST_READY_WAIT;
        end
        nxt_timer = '0;
      end
      reset_seq_pkg::ST_READY_WAIT: begin
        if (start_ok) begin
          nxt_state = reset_seq_pkg::ST_TIMER;
        end
        nxt_timer = '0;
      end
      reset_seq_pkg::ST_TIMER: begin
        if (power_up_timer_enable_n_in) begin
          nxt_state = reset_seq_pkg::ST_RUN;
        end else if (timer_ff == TIMER_LAST) begin
          nxt_state = reset_seq_pkg::ST_RUN;
        end else begin
          nxt_timer = timer_ff + 1'h1;
        end
      end
      reset_seq_pkg::ST_RUN: begin
        nxt_timer = '0;
      end
      reset_seq_pkg::ST_BROWNOUT: begin
        // Stays here until the supply recovers; the timer then restarts.
        if (!filt.tripped) begin
          nxt_state = reset_seq_pkg::ST_READY_WAIT;
        end
        nxt_timer = '0;
      end
      default: begin
        nxt_state = reset_seq_pkg::ST_POWER_ON;
        nxt_timer = '0;
      end
    endcase
    if (filt.tripped) begin
      nxt_state = reset_seq_pkg::ST_BROWNOUT;
    end
    if (supply_low_in) begin
      nxt_state = reset_seq_pkg::ST_POWER_ON;
    end
  end

  // Outputs and software bit.
  always_comb begin
    nxt_core_reset = (nxt_state != reset_seq_pkg::ST_RUN);
    // Only the off-in-sleep mode holds the wake on the ready signal.
    nxt_wake_hold  = (brownout_mode_select_in ==
                      reset_seq_pkg::MODE_ON_AWAKE) &&
                     !brownout_ready_in;
    nxt_bor_en     = bor_active;
    nxt_bor_rst    = filt.tripped;
    nxt_soft_en    = soft_en_ff;
    if (reg_write_in &&
        reg_addr_in == reset_seq_pkg::BROWNOUT_CONTROL_ADDR) begin
      nxt_soft_en = reg_wdata_in[reset_seq_pkg::SOFT_ENABLE_BIT];
    end
    nxt_rdata = '0;
    if (reg_read_in) begin
      case (reg_addr_in)
        reset_seq_pkg::BROWNOUT_CONTROL_ADDR: begin
          nxt_rdata[reset_seq_pkg::SOFT_ENABLE_BIT] = soft_en_ff;
          nxt_rdata[reset_seq_pkg::READY_BIT] = brownout_ready_in;
        end
        reset_seq_pkg::SEQ_STATUS_ADDR: begin
          nxt_rdata[4:0] = state_ff;
          nxt_rdata[7]   = core_reset_ff;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_ff      <= reset_seq_pkg::ST_POWER_ON;
      timer_ff      <= '0;
      soft_en_ff    <= reset_seq_pkg::SOFT_ENABLE_RESET;
      core_reset_ff <= 1'h1;
      wake_hold_ff  <= 1'h1;
      bor_en_ff     <= 1'h0;
      bor_rst_ff    <= 1'h0;
      rdata_ff      <= '0;
    end else begin
      state_ff      <= nxt_state;
      timer_ff      <= nxt_timer;
      soft_en_ff    <= nxt_soft_en;
      core_reset_ff <= nxt_core_reset;
      wake_hold_ff  <= nxt_wake_hold;
      bor_en_ff     <= nxt_bor_en;
      bor_rst_ff    <= nxt_bor_rst;
      rdata_ff      <= nxt_rdata;
    end
  end

  assign core_reset_out      = core_reset_ff;
  assign wake_hold_out       = wake_hold_ff;
  assign brownout_enable_out = bor_en_ff;
  assign brownout_reset_out  = bor_rst_ff;
  assign reg_rdata_out       = rdata_ff;
endmodule
`default_nettype wire

/* rtl/reset_seq_pkg.sv */
// Package of constants shared by the reset sequencer files.
package reset_seq_pkg;
  // Clock and timing.
  localparam int unsigned CLK_FREQ_HZ       = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned POWER_UP_TIME_MS  = 64;
  localparam int unsigned POWER_UP_CYCLES   =
    POWER_UP_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned FILTER_TIME_NS    = 1000;
  localparam int unsigned FILTER_CYCLES     =
    (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W           = 21;
  localparam int unsigned FILTER_W          = 8;

  // Brown-out mode field encodings.
  localparam logic [1:0] MODE_OFF           = 2'h0;
  localparam logic [1:0] MODE_SOFT          = 2'h1;
  localparam logic [1:0] MODE_ON_AWAKE      = 2'h2;
  localparam logic [1:0] MODE_ALWAYS        = 2'h3;

  // Register map.
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 8;
  localparam logic [7:0] BROWNOUT_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] SEQ_STATUS_ADDR    = 8'h01;
  localparam int unsigned SOFT_ENABLE_BIT   = 7;
  localparam int unsigned READY_BIT         = 0;
  localparam logic        SOFT_ENABLE_RESET = 1'h1;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_POWER_ON   = 5'h01,
    ST_READY_WAIT = 5'h02,
    ST_TIMER      = 5'h04,
    ST_RUN        = 5'h08,
    ST_BROWNOUT   = 5'h10
  } seq_state_type;
endpackage

/* test/reset_seq_monitor.sv */
// Port checker for the reset sequencer.
`timescale 1ns/100ps
`default_nettype none
module reset_seq_monitor #(
  parameter int unsigned POWER_UP_CYCLES = 20
) (
  input wire logic       ref_clk_in,
  input wire logic       nrst_in,
  input wire logic       supply_low_in,
  input wire logic       below_threshold_in,
  input wire logic       brownout_ready_in,
  input wire logic [1:0] brownout_mode_select_in,
  input wire logic       power_up_timer_enable_n_in,
  input wire logic       sleep_in,
  input wire logic       reg_write_in,
  input wire logic       core_reset_out,
  input wire logic       wake_hold_out,
  input wire logic       brownout_enable_out,
  input wire logic       brownout_reset_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic [21:0] run_ff;
  logic [21:0] nxt_run;
  logic [7:0]  dip_ff;
  logic [7:0]  nxt_dip;
  always_comb begin
    nxt_run = (nrst_in && core_reset_out) ? run_ff + 22'h1 : 22'h0;
    nxt_dip = (nrst_in && below_threshold_in) ? dip_ff + 8'h1 : 8'h0;
  end
  always_ff @(posedge ref_clk_in) begin
    run_ff <= nxt_run;
    dip_ff <= nxt_dip;
  end
  sequence s_hold(logic [1:0] m, logic s);
    (brownout_mode_select_in == m && sleep_in == s && !supply_low_in) [*2];
  endsequence
  property p_por_hold;
    supply_low_in |=> core_reset_out;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("core not held at low supply");
  property p_timer;
    $fell(core_reset_out) && !power_up_timer_enable_n_in
      |-> run_ff >= POWER_UP_CYCLES;
  endproperty
  a_timer: assert property (p_timer)
    else $error("core released before timer end");
  property p_trip;
    $rose(brownout_reset_out) |->
      $past(dip_ff) >= reset_seq_pkg::FILTER_CYCLES;
  endproperty
  a_trip: assert property (p_trip)
    else $error("brown-out tripped on a short dip");
  property p_en_always;
    s_hold(reset_seq_pkg::MODE_ALWAYS, 1'b1) |=> brownout_enable_out;
  endproperty
  a_en_always: assert property (p_en_always)
    else $error("always-on detector off in sleep");
  property p_en_sleep;
    s_hold(reset_seq_pkg::MODE_ON_AWAKE, 1'b1) |=> !brownout_enable_out;
  endproperty
  a_en_sleep: assert property (p_en_sleep)
    else $error("detector on in sleep");
  property p_en_off;
    s_hold(reset_seq_pkg::MODE_OFF, 1'b0) |=> !brownout_enable_out;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("detector on in off mode");
  property p_wake_wait;
    (brownout_mode_select_in == reset_seq_pkg::MODE_ON_AWAKE
      && !brownout_ready_in) [*2] |=> wake_hold_out;
  endproperty
  a_wake_wait: assert property (p_wake_wait)
    else $error("wake not held for ready");
  property p_wake_free;
    (brownout_mode_select_in == reset_seq_pkg::MODE_ALWAYS) [*2]
      |=> !wake_hold_out;
  endproperty
  a_wake_free: assert property (p_wake_free)
    else $error("wake held in always-on mode");
  // Sleep is deliberately left free here: only it may change.
  property p_soft;
    (brownout_mode_select_in == reset_seq_pkg::MODE_SOFT && !reg_write_in
      && $stable(brownout_ready_in) && !supply_low_in) [*3]
      |-> $stable(brownout_enable_out);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft mode enable moved with sleep");
endmodule
bind brownout_powerup_reset reset_seq_monitor #(
  .POWER_UP_CYCLES(POWER_UP_CYCLES)
) mon (
  .ref_clk_in, .nrst_in, .supply_low_in, .below_threshold_in,
  .brownout_ready_in, .brownout_mode_select_in, .power_up_timer_enable_n_in,
  .sleep_in, .reg_write_in, .core_reset_out, .wake_hold_out,
  .brownout_enable_out, .brownout_reset_out
);
`default_nettype wire

/* test/supply_model.sv */
// Behavioural model of the supply detectors facing the sequencer.
`timescale 1ns/100ps
`default_nettype none
module supply_model (
  // Clock
  input  wire logic ref_clk_in,
  // Requested supply conditions
  input  wire logic low_req_in,
  input  wire logic dip_req_in,
  input  wire logic ready_req_in,
  // Detector outputs
  output logic      supply_low_out,
  output logic      below_threshold_out,
  output logic      brownout_ready_out
);
  // A supply under its minimum is also under the brown-out level, and the
  // detector cannot report ready until the supply is back.
  always_ff @(posedge ref_clk_in) begin
    supply_low_out      <= low_req_in;
    below_threshold_out <= dip_req_in | low_req_in;
    brownout_ready_out  <= ready_req_in & ~low_req_in;
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the reset sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned P = 20;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       low_req = 1'b1;
  logic       dip_req = 1'b0;
  logic       rdy_req = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       en_n = 1'b1;
  logic       sleep = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       s_low, s_below, s_rdy, c_rst, w_hold, bo_en, bo_rst;
  logic [7:0] rdata;
  logic [7:0] d;
  int         err_count = 0;
  int         n_checks = 0;
  supply_model sup (.ref_clk_in(clk), .low_req_in(low_req),
    .dip_req_in(dip_req), .ready_req_in(rdy_req), .supply_low_out(s_low),
    .below_threshold_out(s_below), .brownout_ready_out(s_rdy));
  brownout_powerup_reset #(.POWER_UP_CYCLES(P)) dut (.ref_clk_in(clk),
    .nrst_in(nrst), .supply_low_in(s_low), .below_threshold_in(s_below),
    .brownout_ready_in(s_rdy), .brownout_mode_select_in(mode),
    .power_up_timer_enable_n_in(en_n), .sleep_in(sleep),
    .core_reset_out(c_rst), .wake_hold_out(w_hold),
    .brownout_enable_out(bo_en), .brownout_reset_out(bo_rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdata));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait so a stuck reset ends the run instead of hanging it.
  task automatic wait_rel(input int lim);
    int i;
    for (i = 0; i < lim && c_rst !== 1'b0; i++) begin
      @(posedge clk);
    end
    if (i == lim) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
    @(posedge clk);
    check("rdata drop", rdata, 8'h00);
  endtask
  task automatic power(input logic [1:0] m, input logic e, r);
    @(posedge clk);
    mode <= m;
    en_n <= e;
    rdy_req <= r;
    low_req <= 1'b1;
    tick(4);
    check("por hold", c_rst, 1'b1);
    low_req <= 1'b0;
  endtask
  task automatic t_off();
    power(reset_seq_pkg::MODE_OFF, 1'b1, 1'b0);
    tick(6);
    check("start at once", c_rst, 1'b0);
    $display("t_off done");
  endtask
  task automatic t_timer();
    power(reset_seq_pkg::MODE_OFF, 1'b0, 1'b0);
    tick(P);
    check("timer hold", c_rst, 1'b1);
    wait_rel(10);
    $display("t_timer done");
  endtask
  task automatic t_wait();
    for (int i = 1; i < 4; i++) begin
      power(i[1:0], 1'b1, 1'b0);
      tick(10);
      check("ready wait", c_rst, {7'h0, i != 1});
      rdy_req <= 1'b1;
      wait_rel(10);
      tick(3);
      check("detector on", bo_en, 1'b1);
    end
    $display("t_wait done");
  endtask
  task automatic t_soft();
    mode <= reset_seq_pkg::MODE_SOFT;
    rd_reg(reset_seq_pkg::BROWNOUT_CONTROL_ADDR, d);
    check("ctrl reset", d, 8'h81);
    sleep <= 1'b1;
    tick(3);
    check("soft sleep", bo_en, 1'b1);
    sleep <= 1'b0;
    wr_reg(reset_seq_pkg::BROWNOUT_CONTROL_ADDR, 8'h00);
    tick(3);
    check("soft off", bo_en, 1'b0);
    wr_reg(reset_seq_pkg::SEQ_STATUS_ADDR, 8'hff);
    rd_reg(reset_seq_pkg::SEQ_STATUS_ADDR, d);
    check("status", d, 8'h08);
    rd_reg(8'h7f, d);
    check("unmapped", d, 8'h00);
    rd_reg(reset_seq_pkg::BROWNOUT_CONTROL_ADDR, d);
    check("ctrl cleared", d, 8'h01);
    wr_reg(reset_seq_pkg::BROWNOUT_CONTROL_ADDR, 8'h80);
    $display("t_soft done");
  endtask
  task automatic t_sleep();
    mode <= reset_seq_pkg::MODE_ON_AWAKE;
    sleep <= 1'b1;
    tick(3);
    check("sleep off", bo_en, 1'b0);
    rdy_req <= 1'b0;
    tick(3);
    check("wake held", w_hold, 1'b1);
    mode <= reset_seq_pkg::MODE_ALWAYS;
    tick(3);
    check("sleep on", bo_en, 1'b1);
    check("wake free", w_hold, 1'b0);
    sleep <= 1'b0;
    rdy_req <= 1'b1;
    $display("t_sleep done");
  endtask
  task automatic t_brown();
    power(reset_seq_pkg::MODE_ALWAYS, 1'b0, 1'b1);
    wait_rel(P + 20);
    dip_req <= 1'b1;
    tick(10);
    dip_req <= 1'b0;
    tick(6);
    check("short dip", bo_rst, 1'b0);
    check("short run", c_rst, 1'b0);
    dip_req <= 1'b1;
    tick(40);
    check("long dip", bo_rst, 1'b1);
    check("dip hold", c_rst, 1'b1);
    dip_req <= 1'b0;
    tick(P);
    check("timer again", c_rst, 1'b1);
    wait_rel(20);
    $display("t_brown done");
  endtask
  initial begin
    tick(8);
    nrst <= 1'b1;
    t_off();
    t_timer();
    t_wait();
    t_soft();
    t_sleep();
    t_brown();
    summarize();
  end
endmodule
`default_nettype wire
